// *** hw/nfcd_host.sv ***
`timescale 1ns/1ps
module nfcd_host (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // command port
    input wire logic req_valid,
    input wire nfcd_pkg::nfcd_req_type req,
    output logic req_ready,
    output logic rsp_valid,
    output nfcd_pkg::nfcd_rsp_type rsp,
    // mode status
    output logic bypass_mode,
    output logic ident_mode,
    output logic erase_window_open,
    output logic erase_suspended,
    // flash pins
    output logic [19:0] fl_addr,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_i,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n
);
    import nfcd_pkg::*;

    // ****************************************
    // cycle table
    // ****************************************
    function automatic nfcd_cyc_type seq_cycle(input nfcd_req_type r, input logic [2:0] i);
        logic [19:0] u1;
        logic [19:0] u2;
        logic [7:0] cd;
        nfcd_cyc_type c;
        u1 = r.byte_mode ? ADR_B1 : ADR_W1;
        u2 = r.byte_mode ? ADR_B2 : ADR_W2;
        c = '{rd: 1'b0, last: 1'b0, addr: u1, data: 16'h0000};
        cd = DAT_ZERO;
        case (r.cmd)
            C_READ: begin
                c.rd = 1'b1;
                c.addr = r.addr;
                c.last = 1'b1;
            end
            C_RESET, C_SUSPEND, C_RESUME: begin
                c.addr = r.addr;
                c.last = 1'b1;
                case (r.cmd)
                    C_RESET: cd = DAT_RESET;
                    C_SUSPEND: cd = DAT_SUSP;
                    default: cd = DAT_SECT;
                endcase
            end
            C_QUERY: begin
                c.addr = r.byte_mode ? ADR_QB : ADR_QW;
                cd = DAT_QUERY;
                c.last = 1'b1;
            end
            C_SECT_ADD: begin
                c.addr = r.addr;
                cd = DAT_SECT;
                c.last = 1'b1;
            end
            C_BYP_PROG: begin
                c.addr = (i == 3'd0) ? u1 : r.addr;
                cd = DAT_PROG;
                c.last = (i == 3'd1);
            end
            C_BYP_OUT: begin
                cd = (i == 3'd0) ? DAT_IDENT : DAT_ZERO;
                c.last = (i == 3'd1);
            end
            default: begin
                // unlock pair then command, some with extra cycles
                if (i == 3'd1 || i == 3'd4) begin
                    c.addr = u2;
                    cd = DAT_UNLK2;
                end else if (i != 3'd2) begin
                    cd = DAT_UNLK1;
                end
                if (i == 3'd2) begin
                    case (r.cmd)
                        C_IDENT, C_OTP_OUT: cd = DAT_IDENT;
                        C_OTP_IN: cd = DAT_OTP;
                        C_PROG: cd = DAT_PROG;
                        C_BYP_IN: cd = DAT_BYPASS;
                        default: cd = DAT_ESETUP;
                    endcase
                    c.last = (r.cmd == C_OTP_IN) || (r.cmd == C_BYP_IN);
                end
                if (i == 3'd3 && r.cmd != C_CHIP_ERASE && r.cmd != C_SECT_ERASE) begin
                    c.last = 1'b1;
                    c.addr = r.addr;
                    if (r.cmd == C_IDENT) begin
                        c.rd = 1'b1;
                        c.addr = r.byte_mode ? {r.addr[18:0], 1'b0} : r.addr;
                    end else if (r.cmd == C_OTP_OUT) begin
                        cd = DAT_ZERO;
                    end
                end
                if (i == 3'd5) begin
                    c.last = 1'b1;
                    if (r.cmd == C_SECT_ERASE) begin
                        c.addr = r.addr;
                        cd = DAT_SECT;
                    end else begin
                        cd = DAT_CHIP;
                    end
                end
            end
        endcase
        if (r.cmd == C_PROG && i == 3'd3 || r.cmd == C_BYP_PROG && i == 3'd1) begin
            c.data = r.data;
        end else begin
            c.data = {8'h00, cd};
        end
        return c;
    endfunction

    // ****************************************
    // admission by tracked mode
    // ****************************************
    function automatic logic allowed(input nfcd_cmd_type k, input logic byp, input logic win,
                                     input logic ers, input logic sus);
        logic ok;
        ok = 1'b1;
        if (byp) begin
            ok = (k == C_BYP_PROG) || (k == C_BYP_OUT) || (k == C_RESET) || (k == C_READ);
        end else begin
            case (k)
                C_BYP_PROG, C_BYP_OUT: ok = 1'b0;
                C_QUERY: ok = !ers;
                C_SECT_ADD: ok = win;
                C_SUSPEND: ok = ers && !sus;
                C_RESUME: ok = sus;
                C_CHIP_ERASE, C_SECT_ERASE, C_BYP_IN, C_OTP_IN, C_OTP_OUT: ok = !ers;
                default: ok = 1'b1;
            endcase
        end
        return ok;
    endfunction

    typedef enum logic [2:0] {S_IDLE, S_SET, S_PULSE, S_REC, S_RDWAIT, S_DONE} nfcd_state_type;

    nfcd_state_type state_q;
    nfcd_req_type req_q;
    nfcd_cyc_type cyc;
    logic [2:0] idx_q;
    logic [3:0] cnt_q;
    logic [15:0] dq_s1_q;
    logic [15:0] dq_s2_q;
    logic [15:0] rdat_q;
    logic err_q;
    logic byp_q;
    logic id_q;
    logic ers_q;
    logic sus_q;
    logic [9:0] win_q;

    assign cyc = seq_cycle(req_q, idx_q);
    assign req_ready = (state_q == S_IDLE);
    assign bypass_mode = byp_q;
    assign ident_mode = id_q;
    assign erase_window_open = (win_q != 10'h000);
    assign erase_suspended = sus_q;

    // ****************************************
    // data pin synchroniser
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end else begin
            dq_s1_q <= fl_dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // ****************************************
    // bus cycle sequencer
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= S_IDLE;
            req_q <= '0;
            idx_q <= 3'd0;
            cnt_q <= 4'h0;
            err_q <= 1'b0;
            rdat_q <= 16'h0000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    idx_q <= 3'd0;
                    if (req_valid) begin
                        req_q <= req;
                        err_q <= !allowed(req.cmd, byp_q, erase_window_open, ers_q, sus_q);
                        state_q <= allowed(req.cmd, byp_q, erase_window_open, ers_q, sus_q)
                                   ? S_SET : S_DONE;
                    end
                end
                S_SET: begin
                    // address, data, ce and the strobe are all driven on the same edge
                    cnt_q <= cyc.rd ? ACC_CYC : WP_CYC;
                    state_q <= cyc.rd ? S_RDWAIT : S_PULSE;
                end
                S_PULSE: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        cnt_q <= WPH_CYC;
                        state_q <= S_REC;
                    end
                end
                S_RDWAIT: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        rdat_q <= req_q.byte_mode ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
                        cnt_q <= WPH_CYC;
                        state_q <= S_REC;
                    end
                end
                S_REC: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        idx_q <= idx_q + 3'd1;
                        state_q <= cyc.last ? S_DONE : S_SET;
                    end
                end
                S_DONE: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fl_addr <= 20'h00000;
            fl_dq_o <= 16'h0000;
            fl_dq_oe <= 1'b0;
            fl_ce_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
        end else begin
            case (state_q)
                S_SET: begin
                    fl_addr <= cyc.addr;
                    fl_dq_o <= cyc.data;
                    fl_dq_oe <= !cyc.rd;
                    fl_ce_n <= 1'b0;
                    fl_oe_n <= !cyc.rd;
                    fl_we_n <= cyc.rd;
                end
                S_PULSE, S_RDWAIT: begin
                    if (cnt_q == 4'h1) begin
                        // we and ce rise together; data and address held past it
                        fl_we_n <= 1'b1;
                        fl_ce_n <= 1'b1;
                        fl_oe_n <= 1'b1;
                    end
                end
                S_REC: begin
                    if (cnt_q == 4'h1) begin
                        fl_dq_oe <= 1'b0;
                    end
                end
                default: begin
                    fl_ce_n <= 1'b1;
                    fl_we_n <= 1'b1;
                    fl_oe_n <= 1'b1;
                    fl_dq_oe <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // answer
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= (state_q == S_DONE);
            if (state_q == S_DONE) begin
                rsp.err <= err_q;
                rsp.data <= (!err_q && req_q.cmd inside {C_READ, C_IDENT}) ? rdat_q : 16'h0000;
            end
        end
    end

    // ****************************************
    // mode tracking
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            byp_q <= 1'b0;
            id_q <= 1'b0;
            ers_q <= 1'b0;
            sus_q <= 1'b0;
            win_q <= 10'h000;
        end else begin
            if (win_q != 10'h000) begin
                win_q <= win_q - 10'h001;
            end
            if (state_q == S_DONE && !err_q) begin
                case (req_q.cmd)
                    C_RESET: begin
                        // also ends a pending window or tracked erase
                        byp_q <= 1'b0;
                        id_q <= 1'b0;
                        ers_q <= 1'b0;
                        sus_q <= 1'b0;
                        win_q <= 10'h000;
                    end
                    C_IDENT: id_q <= 1'b1;
                    C_BYP_IN: byp_q <= 1'b1;
                    C_BYP_OUT: byp_q <= 1'b0;
                    C_SECT_ERASE, C_SECT_ADD: begin
                        ers_q <= 1'b1;
                        win_q <= EWIN_CYC;
                    end
                    C_SUSPEND: begin
                        sus_q <= 1'b1;
                        win_q <= 10'h000;
                    end
                    C_RESUME: sus_q <= 1'b0;
                    default: id_q <= id_q;
                endcase
            end
        end
    end
endmodule

// *** hw/nfcd_pkg.sv ***
// Notes on behaviour
// - one F0 write anywhere returns to array read; used to leave identification.
// - all command cycles are writes except array reads and the identification read.
// - in array-read mode any read returns data without prior commands.
// - identification: AA@555, 55@2AA, 90@555, then read offset 00 or 01.
// - byte mode unlock addresses AAA, 555, AAA; identification offsets double.
// - region entry: AA@555, 55@2AA, 88@555.
// - region exit: AA@555, 55@2AA, 90@555, 00 anywhere.
// - query: 98 at 55 (AA byte), only from read or identification mode; the host admits it whenever not in bypass and no sector erase is tracked.
// - program: AA@555, 55@2AA, A0@555, then data at program address.
// - bypass entry AA, 55, 20; bypass program is A0 then data.
// - bypass left by 90 then 00, or by a single F0.
// - chip erase: AA, 55, 80, AA, 55, then 10 at 555.
// - sector erase: same five writes, then 30 at sector address.
// - within the erase window each added sector is one 30 write.
// - after sector erase a 50 us window admits more sectors.
package nfcd_pkg;
    // ****************************************
    // command codes and unlock addresses
    // ****************************************
    localparam logic [7:0] DAT_UNLK1 = 8'haa;
    localparam logic [7:0] DAT_UNLK2 = 8'h55;
    localparam logic [7:0] DAT_RESET = 8'hf0;
    localparam logic [7:0] DAT_IDENT = 8'h90;
    localparam logic [7:0] DAT_OTP = 8'h88;
    localparam logic [7:0] DAT_ZERO = 8'h00;
    localparam logic [7:0] DAT_QUERY = 8'h98;
    localparam logic [7:0] DAT_PROG = 8'ha0;
    localparam logic [7:0] DAT_BYPASS = 8'h20;
    localparam logic [7:0] DAT_ESETUP = 8'h80;
    localparam logic [7:0] DAT_CHIP = 8'h10;
    localparam logic [7:0] DAT_SECT = 8'h30;
    localparam logic [7:0] DAT_SUSP = 8'hb0;
    localparam logic [19:0] ADR_W1 = 20'h00555;
    localparam logic [19:0] ADR_W2 = 20'h002aa;
    localparam logic [19:0] ADR_B1 = 20'h00aaa;
    localparam logic [19:0] ADR_B2 = 20'h00555;
    localparam logic [19:0] ADR_QW = 20'h00055;
    localparam logic [19:0] ADR_QB = 20'h000aa;
    // ****************************************
    // timing, 10 MHz reference
    // ****************************************
    localparam int CLK_NS = 100;
    localparam int T_WP_NS = 35;
    localparam int T_WPH_NS = 30;
    localparam int T_ACC_NS = 70;
    localparam int T_EWIN_US = 50;
    localparam int SYNC_CYC = 2;
    localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WPH_CYC = 4'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
    localparam logic [9:0] EWIN_CYC = 10'((T_EWIN_US * 1000) / CLK_NS);
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        C_READ, C_RESET, C_IDENT, C_OTP_IN, C_OTP_OUT, C_QUERY, C_PROG, C_BYP_IN,
        C_BYP_PROG, C_BYP_OUT, C_CHIP_ERASE, C_SECT_ERASE, C_SECT_ADD, C_SUSPEND, C_RESUME
    } nfcd_cmd_type;
    typedef struct packed {
        nfcd_cmd_type cmd;
        logic byte_mode;
        logic [19:0] addr;
        logic [15:0] data;
    } nfcd_req_type;
    typedef struct packed {
        logic err;
        logic [15:0] data;
    } nfcd_rsp_type;
    typedef struct packed {
        logic rd;
        logic last;
        logic [19:0] addr;
        logic [15:0] data;
    } nfcd_cyc_type;
endpackage

// *** bench/nfcd_flash_model.sv ***
`timescale 1ns/1ps
module nfcd_flash_model #(
    parameter logic [15:0] MAKER = 16'h00a7, // arbitrary value
    parameter logic [15:0] DEVICE = 16'h5e3b // arbitrary value
) (
    // flash pins
    input wire logic [19:0] fl_addr,
    input wire logic [15:0] fl_dq_o,
    input wire logic fl_dq_oe,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic fl_byte,
    // data driven back
    output logic [15:0] fl_dq
);
    logic [19:0] log_a[$];
    logic [15:0] log_d[$];
    logic [19:0] lat_a = 20'h00000;
    logic [59:0] hist = 60'h0;
    logic wr_on = 1'b0;
    logic ident_q = 1'b0;
    logic [15:0] last = 16'h0000;
    logic [15:0] rv;
    logic [15:0] id;
    logic [11:0] u1;
    logic [11:0] u2;
    logic [7:0] off;
    assign u1 = fl_byte ? 12'haaa : 12'h555;
    assign u2 = fl_byte ? 12'h555 : 12'h2aa;
    // address on the later falling strobe, data on the earlier rising one
    always @(negedge fl_we_n or negedge fl_ce_n) begin
        if (!fl_we_n && !fl_ce_n) begin
            lat_a = fl_addr;
            wr_on = 1'b1;
        end
    end
    always @(posedge fl_we_n or posedge fl_ce_n) begin
        if (wr_on) begin
            wr_on = 1'b0;
            log_a.push_back(lat_a);
            log_d.push_back(fl_dq_oe ? fl_dq_o : 16'hxxxx);
            hist = {hist[39:0], lat_a[11:0], fl_dq_o[7:0]};
            if (fl_dq_o[7:0] == 8'hf0 || fl_dq_o[7:0] == 8'h00) begin
                ident_q = 1'b0;
            end else if (hist == {u1, 8'haa, u2, 8'h55, u1, 8'h90}) begin
                ident_q = 1'b1;
            end
        end
    end
    always_comb begin
        off = fl_byte ? fl_addr[8:1] : fl_addr[7:0];
        id = (off == 8'h00) ? MAKER : (off == 8'h01) ? DEVICE : {15'h0, ^fl_addr[19:12]};
        rv = ident_q ? id : fl_addr[15:0] ^ 16'h3c5a;
    end
    // a released bus shows the inverse of the last value, never a held copy
    always @(posedge fl_oe_n) last = fl_dq;
    assign fl_dq = (!fl_ce_n && !fl_oe_n) ? rv : ~last;
endmodule

// *** bench/nfcd_host_chk.sv ***
`timescale 1ns/1ps
module nfcd_host_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // command port
    input wire logic req_valid,
    input wire nfcd_pkg::nfcd_req_type req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire nfcd_pkg::nfcd_rsp_type rsp,
    // mode status
    input wire logic bypass_mode,
    input wire logic erase_window_open,
    input wire logic erase_suspended,
    // flash strobes
    input wire logic fl_dq_oe,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n
);
    import nfcd_pkg::*;
    wire logic take = req_valid && req_ready;
    nfcd_cmd_type cmd_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_q <= C_READ;
        end else if (take) begin
            cmd_q <= req.cmd;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // ****************
    // assertions
    // ****************
    property p_wr; !fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe; endproperty
    a_wr: assert property (p_wr) else $error("bad write strobe");
    property p_rd; !fl_oe_n |-> !fl_ce_n && !fl_dq_oe; endproperty
    a_rd: assert property (p_rd) else $error("bad read strobe");
    property p_pulse; $fell(fl_we_n) |=> fl_we_n && fl_ce_n; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse too long");
    property p_ans; take |=> !req_ready ##[1:40] rsp_valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_byp; take && bypass_mode && !(req.cmd inside {C_BYP_PROG, C_BYP_OUT,
        C_RESET, C_READ}) |=> fl_ce_n [*2] ##0 rsp_valid && rsp.err; endproperty
    a_byp: assert property (p_byp) else $error("bypass refusal");
    property p_res; take && req.cmd == C_RESUME && !erase_suspended |-> ##2 rsp.err; endproperty
    a_res: assert property (p_res) else $error("resume refusal");
    property p_add; take && req.cmd == C_SECT_ADD && !erase_window_open |-> ##2 rsp.err; endproperty
    a_add: assert property (p_add) else $error("add refusal");
    property p_sus; rsp_valid && !rsp.err && cmd_q == C_SUSPEND |->
        ##[0:1] erase_suspended && !erase_window_open; endproperty
    a_sus: assert property (p_sus) else $error("suspend mode");
    property p_bx; rsp_valid && !rsp.err && cmd_q inside {C_BYP_OUT, C_RESET} |->
        ##[0:1] !bypass_mode; endproperty
    a_bx: assert property (p_bx) else $error("bypass exit");
    property p_win; rsp_valid && !rsp.err && cmd_q == C_SECT_ERASE |->
        ##[0:1] erase_window_open; endproperty
    a_win: assert property (p_win) else $error("window closed");
    c_sect: cover property (take && req.cmd == C_SECT_ERASE);
    c_err: cover property (rsp_valid && rsp.err);
    c_bprog: cover property (take && bypass_mode && req.cmd == C_BYP_PROG);
endmodule
bind nfcd_host nfcd_host_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .bypass_mode(bypass_mode), .erase_window_open(erase_window_open),
    .erase_suspended(erase_suspended), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import nfcd_pkg::*;
    localparam logic [15:0] MAKER = 16'h00a7; // arbitrary value
    localparam logic [15:0] DEVICE = 16'h5e3b; // arbitrary value
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    nfcd_req_type req = '0;
    nfcd_rsp_type rsp;
    logic req_ready, rsp_valid, bypass_mode, ident_mode, erase_window_open, erase_suspended;
    logic [19:0] fl_addr;
    logic [15:0] fl_dq_o, fl_dq_i;
    logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
    logic [31:0] r;
    int mismatches = 0;
    int n_checks = 0;
    logic [19:0] ea[$];
    logic [15:0] ed[$];
    logic [1:0] ef[$];
    always #50 ref_clk = ~ref_clk;
    nfcd_host u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .bypass_mode(bypass_mode),
        .ident_mode(ident_mode), .erase_window_open(erase_window_open),
        .erase_suspended(erase_suspended), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n));
    nfcd_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) u_flash (.fl_addr(fl_addr),
        .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n), .fl_byte(req.byte_mode), .fl_dq(fl_dq_i));
    // ****************
    // checking helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // f bit0: address compared, bit1: whole word compared
    task automatic ex(input logic [19:0] a, input logic [15:0] d, input logic [1:0] f);
        ea.push_back(a);
        ed.push_back(d);
        ef.push_back(f);
    endtask
    task automatic ul(input logic bm, input logic [7:0] d);
        ex(bm ? ADR_B1 : ADR_W1, 16'h00aa, 2'd1);
        ex(bm ? ADR_B2 : ADR_W2, 16'h0055, 2'd1);
        ex(bm ? ADR_B1 : ADR_W1, {8'h00, d}, 2'd1);
    endtask
    function automatic logic [15:0] exp_rd(input logic bm, input logic id, input logic [19:0] a);
        logic [15:0] v;
        v = a[15:0] ^ 16'h3c5a;
        if (id) v = (a[7:0] == 8'h00) ? MAKER : (a[7:0] == 8'h01) ? DEVICE : {15'h0, ^a[19:12]};
        return bm ? {8'h00, v[7:0]} : v;
    endfunction
    // md is {bypass, ident, window, suspended} after the answer
    task automatic run(input nfcd_cmd_type c, input logic bm, input logic [19:0] a,
            input logic [15:0] d, input logic err, input logic [3:0] md);
        logic [15:0] rv = 16'h0000;
        int k = 0;
        ea.delete();
        ed.delete();
        ef.delete();
        u_flash.log_a.delete();
        u_flash.log_d.delete();
        if (!err) begin
            case (c)
                C_READ: rv = exp_rd(bm, 1'b0, a);
                C_RESET: ex(a, 16'h00f0, 2'd0);
                C_IDENT: begin
                    ul(bm, 8'h90);
                    rv = exp_rd(bm, 1'b1, a);
                end
                C_OTP_IN: ul(bm, 8'h88);
                C_OTP_OUT: begin
                    ul(bm, 8'h90);
                    ex(a, 16'h0000, 2'd0);
                end
                C_QUERY: ex(bm ? ADR_QB : ADR_QW, 16'h0098, 2'd1);
                C_PROG: begin
                    ul(bm, 8'ha0);
                    ex(a, d, 2'd3);
                end
                C_BYP_IN: ul(bm, 8'h20);
                C_BYP_PROG: begin
                    ex(a, 16'h00a0, 2'd0);
                    ex(a, d, 2'd3);
                end
                C_BYP_OUT: begin
                    ex(a, 16'h0090, 2'd0);
                    ex(a, 16'h0000, 2'd0);
                end
                C_CHIP_ERASE: begin
                    ul(bm, 8'h80);
                    ul(bm, 8'h10);
                end
                C_SECT_ERASE: begin
                    ul(bm, 8'h80);
                    ex(bm ? ADR_B1 : ADR_W1, 16'h00aa, 2'd1);
                    ex(bm ? ADR_B2 : ADR_W2, 16'h0055, 2'd1);
                    ex(a, 16'h0030, 2'd1);
                end
                C_SECT_ADD: ex(a, 16'h0030, 2'd1);
                C_SUSPEND: ex(a, 16'h00b0, 2'd0);
                default: ex(a, 16'h0030, 2'd0);
            endcase
        end
        while (req_ready !== 1'b1 && k < 100) begin
            @(negedge ref_clk);
            k++;
        end
        chk(req_ready, 1'b1);
        req_valid = 1'b1;
        req = '{cmd: c, byte_mode: bm, addr: a, data: d};
        @(negedge ref_clk);
        req_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 100) begin
            @(negedge ref_clk);
            k++;
        end
        chk(rsp_valid, 1'b1);
        chk({15'h0, rsp.err, rsp.data}, {15'h0, err, rv});
        chk(u_flash.log_a.size(), ea.size());
        if (u_flash.log_a.size() == ea.size()) begin
            foreach (ea[i]) begin
                chk(ef[i][0] ? u_flash.log_a[i] : 20'h0, ef[i][0] ? ea[i] : 20'h0);
                chk(ef[i][1] ? u_flash.log_d[i] : {8'h0, u_flash.log_d[i][7:0]}, ed[i]);
            end
        end
        @(negedge ref_clk);
        chk({bypass_mode, ident_mode, erase_window_open, erase_suspended}, md);
        $display("test cmd=%0d byte=%0d done", c, bm);
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        void'($urandom(91));
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        chk({req_ready, fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe, rsp_valid}, 6'b111100);
        for (int i = 0; i < 6; i++) begin
            run(C_READ, i[0], 20'($urandom), 16'h0, 1'b0, 4'h0);
        end
        for (int i = 0; i < 4; i++) begin
            run(C_IDENT, i[1], 20'(i[0]), 16'h0, 1'b0, 4'h4);
            run(C_RESET, i[1], 20'($urandom), 16'h0, 1'b0, 4'h0);
            run(C_QUERY, i[0], 20'h0, 16'h0, 1'b0, 4'h0);
            run(C_OTP_IN, i[0], 20'h0, 16'h0, 1'b0, 4'h0);
            run(C_OTP_OUT, i[0], 20'($urandom), 16'h0, 1'b0, 4'h0);
            run(C_PROG, i[0], 20'($urandom), 16'($urandom), 1'b0, 4'h0);
        end
        r = $urandom;
        run(C_IDENT, 1'b0, {r[7:0], 12'h002}, 16'h0, 1'b0, 4'h4);
        run(C_RESET, 1'b0, 20'h0, 16'h0, 1'b0, 4'h0);
        run(C_BYP_PROG, 1'b0, 20'h0, 16'h1234, 1'b1, 4'h0);
        run(C_BYP_IN, 1'b1, 20'h0, 16'h0, 1'b0, 4'h8);
        run(C_BYP_PROG, 1'b1, 20'($urandom), 16'($urandom), 1'b0, 4'h8);
        run(C_QUERY, 1'b0, 20'h0, 16'h0, 1'b1, 4'h8);
        run(C_PROG, 1'b0, 20'h0, 16'h0, 1'b1, 4'h8);
        run(C_BYP_OUT, 1'b0, 20'($urandom), 16'h0, 1'b0, 4'h0);
        run(C_BYP_IN, 1'b0, 20'h0, 16'h0, 1'b0, 4'h8);
        run(C_RESET, 1'b0, 20'h0, 16'h0, 1'b0, 4'h0);
        run(C_SUSPEND, 1'b0, 20'h0, 16'h0, 1'b1, 4'h0);
        run(C_RESUME, 1'b0, 20'h0, 16'h0, 1'b1, 4'h0);
        run(C_SECT_ADD, 1'b0, 20'h0, 16'h0, 1'b1, 4'h0);
        run(C_CHIP_ERASE, 1'b1, 20'h0, 16'h0, 1'b0, 4'h0);
        run(C_RESET, 1'b0, 20'h0, 16'h0, 1'b0, 4'h0);
        run(C_SECT_ERASE, 1'b0, 20'h3f000, 16'h0, 1'b0, 4'h2);
        run(C_SECT_ADD, 1'b0, 20'h41000, 16'h0, 1'b0, 4'h2);
        run(C_SUSPEND, 1'b0, 20'h0, 16'h0, 1'b0, 4'h1);
        run(C_QUERY, 1'b0, 20'h0, 16'h0, 1'b1, 4'h1);
        run(C_PROG, 1'b0, 20'h00123, 16'hbeef, 1'b0, 4'h1);
        run(C_RESUME, 1'b0, 20'h0, 16'h0, 1'b0, 4'h0);
        run(C_RESUME, 1'b0, 20'h0, 16'h0, 1'b1, 4'h0);
        run(C_SUSPEND, 1'b0, 20'h0, 16'h0, 1'b0, 4'h1);
        run(C_IDENT, 1'b0, 20'h0, 16'h0, 1'b0, 4'h5);
        run(C_RESET, 1'b0, 20'h0, 16'h0, 1'b0, 4'h0);
        run(C_SECT_ERASE, 1'b1, 20'h20000, 16'h0, 1'b0, 4'h2);
        repeat (470) @(negedge ref_clk);
        chk(erase_window_open, 1'b1);
        repeat (40) @(negedge ref_clk);
        chk(erase_window_open, 1'b0);
        run(C_SECT_ADD, 1'b1, 20'h20000, 16'h0, 1'b1, 4'h0);
        test_done();
    end
    // about a thousand cycles are needed; ample margin
    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
endmodule
